// *** motion_data_pkg.sv ***
// Register indices, field layout and bus codes for the motion sensor data bank
package motion_data_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int SLOT_W = 5;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_GYRO_RAW_XY_WORD = 10'h056;
	localparam logic [9:0] IDX_GYRO_RAW_Z_WORD = 10'h057;
	localparam logic [9:0] IDX_GYRO_RAW_TIMESTAMP = 10'h058;
	localparam logic [9:0] IDX_ACCEL_RAW_XY_WORD = 10'h059;
	localparam logic [9:0] IDX_ACCEL_RAW_Z_WORD = 10'h05a;
	localparam logic [9:0] IDX_ACCEL_RAW_TIMESTAMP = 10'h05b;
	localparam logic [9:0] IDX_MAG_RAW_XY_WORD = 10'h05c;
	localparam logic [9:0] IDX_MAG_RAW_Z_WORD = 10'h05d;
	localparam logic [9:0] IDX_MAG_RAW_TIMESTAMP = 10'h05e;
	localparam logic [9:0] IDX_BOARD_TEMPERATURE = 10'h05f;
	localparam logic [9:0] IDX_BOARD_TEMPERATURE_TIMESTAMP = 10'h060;
	localparam logic [9:0] IDX_RATE_CAL_X = 10'h061;
	localparam logic [9:0] IDX_RATE_CAL_Y = 10'h062;
	localparam logic [9:0] IDX_RATE_CAL_Z = 10'h063;
	localparam logic [9:0] IDX_RATE_CAL_TIMESTAMP = 10'h064;
	localparam logic [9:0] IDX_ACCEL_CAL_X = 10'h065;
	localparam logic [9:0] IDX_ACCEL_CAL_Y = 10'h066;
	localparam logic [9:0] IDX_ACCEL_CAL_Z = 10'h067;
	localparam logic [9:0] IDX_ACCEL_CAL_TIMESTAMP = 10'h068;
	localparam logic [9:0] IDX_FIELD_CAL_X = 10'h069;
	localparam logic [9:0] IDX_FIELD_CAL_Y = 10'h06a;
	localparam logic [9:0] IDX_FIELD_CAL_Z = 10'h06b;
	localparam logic [9:0] IDX_FIELD_CAL_TIMESTAMP = 10'h06c;
	localparam logic [9:0] IDX_ATTITUDE_Q_FIRST_PAIR = 10'h06d;
	localparam logic [9:0] IDX_ATTITUDE_Q_SECOND_PAIR = 10'h06e;
	localparam logic [9:0] IDX_ATTITUDE_Q_TIMESTAMP = 10'h06f;

	localparam logic [9:0] IDX_FIRST = IDX_GYRO_RAW_XY_WORD;
	localparam logic [9:0] IDX_LAST = IDX_ATTITUDE_Q_TIMESTAMP;
	localparam int BANK_WORDS = 26;

	// Packed half-word layout
	localparam int UPPER_LSB = 16;
	localparam int LOWER_LSB = 0;
	localparam logic [15:0] RESERVED_HALF_VALUE = 16'h0000;

	// Quaternion scale: stored value is component times this factor
	localparam real QUAT_SCALE = 29789.09091;

	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

endpackage

// *** sample_bank_store.sv ***
// Word store of the data bank: each word loads on its own strobe
`timescale 1ns/1ps
`default_nettype none

module sample_bank_store
	import motion_data_pkg::*;
#(
	parameter int WORDS = BANK_WORDS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Update side
	input wire logic [WORDS-1:0] word_load,
	input wire logic [WORDS-1:0][31:0] word_din,
	// Read side
	output logic [WORDS-1:0][31:0] word_dout
);

	genvar k;
	generate
		for (k = 0; k < WORDS; k++) begin : g_word
			// One register per word, so each process owns its own variable
			logic [31:0] held_reg;

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					held_reg <= WORD_RESET;
				end else if (word_load[k]) begin
					held_reg <= word_din[k];
				end
			end

			assign word_dout[k] = held_reg;
		end
	endgenerate

endmodule

`default_nettype wire

// *** motion_data_regs.sv ***
// Read-only motion sensor data bank behind an AXI4-Lite slave
//
// Notes on behaviour
// - Gyro X upper, Y lower, signed 16-bit
// - Accel and mag X upper, Y lower
// - Z in upper half, lower half reserved
// - Each raw group has float timestamp
// - Temperature in Celsius as float
// - Temperature acquisition time as float
// - Calibrated rate per axis, consecutive floats
// - Calibrated rate set timestamp as float
// - Calibrated acceleration per axis, consecutive floats
// - Calibrated acceleration set timestamp as float
// - Calibrated field per axis, consecutive floats
// - Calibrated field set timestamp as float
// - Quaternion first, second packed, scaled signed
// - Quaternion third, fourth packed next word
// - Quaternion timestamp follows component words
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module motion_data_regs
	import motion_data_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,

	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,

	// AXI4-Lite write data
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,

	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,

	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,

	// AXI4-Lite read data
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,

	// Raw gyro sample
	input wire logic gyro_raw_load,
	input wire logic [HALF_W-1:0] gyro_raw_x,
	input wire logic [HALF_W-1:0] gyro_raw_y,
	input wire logic [HALF_W-1:0] gyro_raw_z,
	input wire logic [DATA_W-1:0] gyro_raw_time,

	// Raw accelerometer sample
	input wire logic accel_raw_load,
	input wire logic [HALF_W-1:0] accel_raw_x,
	input wire logic [HALF_W-1:0] accel_raw_y,
	input wire logic [HALF_W-1:0] accel_raw_z,
	input wire logic [DATA_W-1:0] accel_raw_time,

	// Raw magnetometer sample
	input wire logic mag_raw_load,
	input wire logic [HALF_W-1:0] mag_raw_x,
	input wire logic [HALF_W-1:0] mag_raw_y,
	input wire logic [HALF_W-1:0] mag_raw_z,
	input wire logic [DATA_W-1:0] mag_raw_time,

	// Board temperature
	input wire logic temp_load,
	input wire logic [DATA_W-1:0] temp_value,
	input wire logic [DATA_W-1:0] temp_time,

	// Calibrated angular rate
	input wire logic rate_cal_load,
	input wire logic [DATA_W-1:0] rate_cal_x_in,
	input wire logic [DATA_W-1:0] rate_cal_y_in,
	input wire logic [DATA_W-1:0] rate_cal_z_in,
	input wire logic [DATA_W-1:0] rate_cal_time,

	// Calibrated acceleration
	input wire logic accel_cal_load,
	input wire logic [DATA_W-1:0] accel_cal_x_in,
	input wire logic [DATA_W-1:0] accel_cal_y_in,
	input wire logic [DATA_W-1:0] accel_cal_z_in,
	input wire logic [DATA_W-1:0] accel_cal_time,

	// Calibrated magnetic field
	input wire logic field_cal_load,
	input wire logic [DATA_W-1:0] field_cal_x_in,
	input wire logic [DATA_W-1:0] field_cal_y_in,
	input wire logic [DATA_W-1:0] field_cal_z_in,
	input wire logic [DATA_W-1:0] field_cal_time,

	// Attitude quaternion, already scaled to signed 16-bit
	input wire logic quat_load,
	input wire logic [HALF_W-1:0] quat_a,
	input wire logic [HALF_W-1:0] quat_b,
	input wire logic [HALF_W-1:0] quat_c,
	input wire logic [HALF_W-1:0] quat_d,
	input wire logic [DATA_W-1:0] quat_time
);

	// True when a byte address falls on a word of the bank
	function automatic logic in_bank(input logic [ADDR_W-1:0] addr);
		logic [9:0] idx;
		idx = addr[ADDR_W-1:2];
		in_bank = (idx >= IDX_FIRST) && (idx <= IDX_LAST);
	endfunction

	// Store slot of a byte address inside the bank
	function automatic logic [SLOT_W-1:0] slot_of(input logic [ADDR_W-1:0] addr);
		logic [9:0] diff;
		diff = addr[ADDR_W-1:2] - IDX_FIRST;
		slot_of = diff[SLOT_W-1:0];
	endfunction

	// Store slot of a register index, fixed at elaboration
	function automatic int slot(input logic [9:0] idx);
		slot = int'(idx - IDX_FIRST);
	endfunction

	// Two signed samples side by side, first one in the upper half
	function automatic logic [31:0] pack_pair(input logic [15:0] hi, input logic [15:0] lo);
		pack_pair = {hi, lo};
	endfunction

	// Axis sample in the upper half, lower half reserved
	function automatic logic [31:0] pack_upper(input logic [15:0] hi);
		pack_upper = {hi, RESERVED_HALF_VALUE};
	endfunction

	// Per-word strobes and data into the store
	logic [BANK_WORDS-1:0] word_load;
	logic [BANK_WORDS-1:0][31:0] word_din;
	logic [BANK_WORDS-1:0][31:0] word_dout;

	// Bus-side state
	logic aw_held_reg;
	logic aw_held_next;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic w_held_reg;
	logic w_held_next;
	logic bvalid_reg;
	logic bvalid_next;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic rvalid_next;
	logic [DATA_W-1:0] rdata_reg;
	logic [1:0] rresp_reg;

	wire logic aw_take;
	wire logic w_take;
	wire logic aw_have;
	wire logic w_have;
	wire logic wr_done;
	wire logic [ADDR_W-1:0] wr_addr;
	wire logic wr_hit;
	wire logic ar_take;
	wire logic rd_hit;
	wire logic [DATA_W-1:0] rd_word;
	wire logic [1:0] wr_resp;
	wire logic [1:0] rd_resp;
	wire logic [SLOT_W-1:0] rd_slot;

	// Each group loads all its words on one strobe, so they stay consistent
	// Gyro X/Y packing
	assign word_din[slot(IDX_GYRO_RAW_XY_WORD)] = pack_pair(gyro_raw_x, gyro_raw_y);
	assign word_load[slot(IDX_GYRO_RAW_XY_WORD)] = gyro_raw_load;
	assign word_din[slot(IDX_GYRO_RAW_Z_WORD)] = pack_upper(gyro_raw_z);
	assign word_load[slot(IDX_GYRO_RAW_Z_WORD)] = gyro_raw_load;
	assign word_din[slot(IDX_GYRO_RAW_TIMESTAMP)] = gyro_raw_time;
	assign word_load[slot(IDX_GYRO_RAW_TIMESTAMP)] = gyro_raw_load;

	assign word_din[slot(IDX_ACCEL_RAW_XY_WORD)] = pack_pair(accel_raw_x, accel_raw_y);
	assign word_load[slot(IDX_ACCEL_RAW_XY_WORD)] = accel_raw_load;
	assign word_din[slot(IDX_ACCEL_RAW_Z_WORD)] = pack_upper(accel_raw_z);
	assign word_load[slot(IDX_ACCEL_RAW_Z_WORD)] = accel_raw_load;
	assign word_din[slot(IDX_ACCEL_RAW_TIMESTAMP)] = accel_raw_time;
	assign word_load[slot(IDX_ACCEL_RAW_TIMESTAMP)] = accel_raw_load;

	assign word_din[slot(IDX_MAG_RAW_XY_WORD)] = pack_pair(mag_raw_x, mag_raw_y);
	assign word_load[slot(IDX_MAG_RAW_XY_WORD)] = mag_raw_load;
	assign word_din[slot(IDX_MAG_RAW_Z_WORD)] = pack_upper(mag_raw_z);
	assign word_load[slot(IDX_MAG_RAW_Z_WORD)] = mag_raw_load;
	assign word_din[slot(IDX_MAG_RAW_TIMESTAMP)] = mag_raw_time;
	assign word_load[slot(IDX_MAG_RAW_TIMESTAMP)] = mag_raw_load;

	assign word_din[slot(IDX_BOARD_TEMPERATURE)] = temp_value;
	assign word_load[slot(IDX_BOARD_TEMPERATURE)] = temp_load;
	assign word_din[slot(IDX_BOARD_TEMPERATURE_TIMESTAMP)] = temp_time;
	assign word_load[slot(IDX_BOARD_TEMPERATURE_TIMESTAMP)] = temp_load;

	assign word_din[slot(IDX_RATE_CAL_X)] = rate_cal_x_in;
	assign word_din[slot(IDX_RATE_CAL_Y)] = rate_cal_y_in;
	assign word_din[slot(IDX_RATE_CAL_Z)] = rate_cal_z_in;
	assign word_load[slot(IDX_RATE_CAL_X)] = rate_cal_load;
	assign word_load[slot(IDX_RATE_CAL_Y)] = rate_cal_load;
	assign word_load[slot(IDX_RATE_CAL_Z)] = rate_cal_load;
	assign word_din[slot(IDX_RATE_CAL_TIMESTAMP)] = rate_cal_time;
	assign word_load[slot(IDX_RATE_CAL_TIMESTAMP)] = rate_cal_load;

	assign word_din[slot(IDX_ACCEL_CAL_X)] = accel_cal_x_in;
	assign word_din[slot(IDX_ACCEL_CAL_Y)] = accel_cal_y_in;
	assign word_din[slot(IDX_ACCEL_CAL_Z)] = accel_cal_z_in;
	assign word_load[slot(IDX_ACCEL_CAL_X)] = accel_cal_load;
	assign word_load[slot(IDX_ACCEL_CAL_Y)] = accel_cal_load;
	assign word_load[slot(IDX_ACCEL_CAL_Z)] = accel_cal_load;
	assign word_din[slot(IDX_ACCEL_CAL_TIMESTAMP)] = accel_cal_time;
	assign word_load[slot(IDX_ACCEL_CAL_TIMESTAMP)] = accel_cal_load;

	assign word_din[slot(IDX_FIELD_CAL_X)] = field_cal_x_in;
	assign word_din[slot(IDX_FIELD_CAL_Y)] = field_cal_y_in;
	assign word_din[slot(IDX_FIELD_CAL_Z)] = field_cal_z_in;
	assign word_load[slot(IDX_FIELD_CAL_X)] = field_cal_load;
	assign word_load[slot(IDX_FIELD_CAL_Y)] = field_cal_load;
	assign word_load[slot(IDX_FIELD_CAL_Z)] = field_cal_load;
	assign word_din[slot(IDX_FIELD_CAL_TIMESTAMP)] = field_cal_time;
	assign word_load[slot(IDX_FIELD_CAL_TIMESTAMP)] = field_cal_load;

	assign word_din[slot(IDX_ATTITUDE_Q_FIRST_PAIR)] = pack_pair(quat_a, quat_b);
	assign word_load[slot(IDX_ATTITUDE_Q_FIRST_PAIR)] = quat_load;
	assign word_din[slot(IDX_ATTITUDE_Q_SECOND_PAIR)] = pack_pair(quat_c, quat_d);
	assign word_load[slot(IDX_ATTITUDE_Q_SECOND_PAIR)] = quat_load;
	assign word_din[slot(IDX_ATTITUDE_Q_TIMESTAMP)] = quat_time;
	assign word_load[slot(IDX_ATTITUDE_Q_TIMESTAMP)] = quat_load;

	// Word storage; every word clears to zero on reset
	sample_bank_store #(
		.WORDS(BANK_WORDS)
	) u_store (
		.aclk(aclk),
		.aresetn(aresetn),
		.word_load(word_load),
		.word_din(word_din),
		.word_dout(word_dout)
	);

	// Write channel: address and data accepted in either order
	// A half taken early is held until its partner arrives
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready = !w_held_reg && !bvalid_reg;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign aw_have = aw_held_reg || aw_take;
	assign w_have = w_held_reg || w_take;
	assign wr_done = aw_have && w_have && !bvalid_reg;
	assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_hit = in_bank(wr_addr);
	assign wr_resp = wr_hit ? RESP_OKAY : RESP_SLVERR;

	assign aw_held_next = wr_done ? 1'b0 : aw_have;
	assign w_held_next = wr_done ? 1'b0 : w_have;
	// No new write is taken while a response waits for bready
	assign bvalid_next = wr_done || (bvalid_reg && !s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			aw_addr_reg <= '0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			bvalid_reg <= bvalid_next;
			// Address kept for a data beat that arrives later
			if (aw_take) begin
				aw_addr_reg <= s_axi_awaddr;
			end
			if (wr_done) begin
				bresp_reg <= wr_resp;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Read channel: one read under way at a time
	// arready stays low while an answer waits, so rdata is never overwritten
	assign s_axi_arready = !rvalid_reg;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign rd_hit = in_bank(s_axi_araddr);
	assign rd_resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
	// Low address bits are ignored; any byte of a word reads the whole word
	assign rd_slot = slot_of(s_axi_araddr);
	assign rd_word = rd_hit ? word_dout[rd_slot] : UNMAPPED_READ;
	assign rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);

	// A load in the same cycle as the address still returns the old word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= UNMAPPED_READ;
			rresp_reg <= RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_resp;
			end
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

endmodule

`default_nettype wire

// *** motion_data_regs_sva.sv ***
// Bus protocol and read-value assertions for the motion data bank
`timescale 1ns/1ps
`default_nettype none

module motion_data_regs_sva
	import motion_data_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wire logic [9:0] ridx = s_axi_araddr[11:2];
	wire logic [9:0] widx = s_axi_awaddr[11:2];
	wire logic r_in = ridx >= IDX_FIRST && ridx <= IDX_LAST;
	wire logic w_in = widx >= IDX_FIRST && widx <= IDX_LAST;
	wire logic z_word = ridx == IDX_GYRO_RAW_Z_WORD || ridx == IDX_ACCEL_RAW_Z_WORD
		|| ridx == IDX_MAG_RAW_Z_WORD;

	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence

	a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read address taken but no read answer");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer not held");
	a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer kept after acceptance");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	a_bank_okay: assert property (rd_taken ##0 r_in |=> s_axi_rresp == RESP_OKAY)
		else $error("in-bank read not answered okay");
	a_unmapped_read: assert property (rd_taken ##0 !r_in |=> s_axi_rresp == RESP_SLVERR
		&& s_axi_rdata == UNMAPPED_READ) else $error("unmapped read answer wrong");
	a_reserved_half: assert property (rd_taken ##0 z_word |=>
		s_axi_rdata[15:0] == RESERVED_HALF_VALUE) else $error("reserved half not zero");
	a_write_okay: assert property (wr_taken ##0 w_in |=> s_axi_bvalid
		&& s_axi_bresp == RESP_OKAY) else $error("in-bank write answer wrong");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write answer not held");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while answer pending");
endmodule

bind motion_data_regs motion_data_regs_sva sva_i (.*);

`default_nettype wire

// *** axi_host_model.sv ***
// Host that reads and writes the bank over AXI4-Lite, one request at a time
`timescale 1ns/1ps
`default_nettype none

module axi_host_model (
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [11:0] s_axi_awaddr = 12'h000,
	output logic s_axi_awvalid = 1'b0,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata = 32'h0000_0000,
	output logic s_axi_wvalid = 1'b0,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready = 1'b0,
	// Read channels
	output logic [11:0] s_axi_araddr = 12'h000,
	output logic s_axi_arvalid = 1'b0,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready = 1'b0
);
	task automatic write_word(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_done;
		logic w_done;
		@(posedge aclk);
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		// Each channel is released only at the edge that takes it
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// bready rises only once the answer is seen, so the slave must hold it
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic read_word(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

`default_nettype wire

// *** tb_motion_sensor_data_regs.sv ***
// Self-checking bench for the motion data bank
`timescale 1ns/1ps
`default_nettype none

module tb_motion_sensor_data_regs;
	import motion_data_pkg::*;
	typedef struct {logic [9:0] idx; logic [31:0] want;} row_t;
	localparam int GROUP_OF[BANK_WORDS] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 4, 4, 4, 4,
		5, 5, 5, 5, 6, 6, 6, 6, 7, 7, 7};
	logic aclk;
	logic aresetn = 1'b0;
	logic [7:0] ld = 8'h00;
	logic [31:0] v [BANK_WORDS];
	row_t rows [BANK_WORDS];
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int fail_count = 0;
	int checks = 0;
	int cycles = 0;

	axi_host_model host (.*);
	motion_data_regs uut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf),
		.gyro_raw_load(ld[0]), .gyro_raw_x(v[0][31:16]), .gyro_raw_y(v[0][15:0]),
		.gyro_raw_z(v[1][31:16]), .gyro_raw_time(v[2]), .accel_raw_load(ld[1]),
		.accel_raw_x(v[3][31:16]), .accel_raw_y(v[3][15:0]), .accel_raw_z(v[4][31:16]),
		.accel_raw_time(v[5]), .mag_raw_load(ld[2]), .mag_raw_x(v[6][31:16]),
		.mag_raw_y(v[6][15:0]), .mag_raw_z(v[7][31:16]), .mag_raw_time(v[8]),
		.temp_load(ld[3]), .temp_value(v[9]), .temp_time(v[10]), .rate_cal_load(ld[4]),
		.rate_cal_x_in(v[11]), .rate_cal_y_in(v[12]), .rate_cal_z_in(v[13]),
		.rate_cal_time(v[14]), .accel_cal_load(ld[5]), .accel_cal_x_in(v[15]),
		.accel_cal_y_in(v[16]), .accel_cal_z_in(v[17]), .accel_cal_time(v[18]),
		.field_cal_load(ld[6]), .field_cal_x_in(v[19]), .field_cal_y_in(v[20]),
		.field_cal_z_in(v[21]), .field_cal_time(v[22]), .quat_load(ld[7]),
		.quat_a(v[23][31:16]), .quat_b(v[23][15:0]), .quat_c(v[24][31:16]),
		.quat_d(v[24][15:0]), .quat_time(v[25]));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			$display("MISMATCH at %0t run exceeded cycle limit", $time);
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	// All sample inputs change; only groups set in the mask may show it
	task automatic load(input logic [7:0] mask, input logic [7:0] s);
		logic [31:0] p;
		@(posedge aclk);
		for (int i = 0; i < BANK_WORDS; i++) begin
			p = {8'h80 ^ s, i[7:0], 8'h7f ^ s, 8'h01 + i[7:0]};
			v[i] <= p;
			if (mask[GROUP_OF[i]]) begin
				rows[i].want = p;
			end
			if (mask[GROUP_OF[i]] && (i == 1 || i == 4 || i == 7)) begin
				rows[i].want[15:0] = RESERVED_HALF_VALUE;
			end
		end
		ld <= mask;
		@(posedge aclk);
		ld <= 8'h00;
	endtask

	task automatic sweep(input string name);
		for (int i = 0; i < BANK_WORDS; i++) begin
			host.read_word({rows[i].idx, 2'b00}, d, r);
			chk(d, rows[i].want);
			chk({30'h0, r}, {30'h0, RESP_OKAY});
		end
		$display("test %s done", name);
	endtask

	initial begin
		for (int i = 0; i < BANK_WORDS; i++) begin
			v[i] = 32'h0000_0000;
			rows[i].idx = IDX_FIRST + 10'(i);
			rows[i].want = WORD_RESET;
		end
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		load(8'hff, 8'h00);
		sweep("all groups");
		load(8'h28, 8'h3c);
		sweep("two groups");
		host.write_word({IDX_RATE_CAL_X, 2'b00}, 32'hffff_ffff, r);
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		host.write_word(12'h1c0, 32'h1234_5678, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		host.read_word(12'h154, d, r);
		chk(d, UNMAPPED_READ);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		host.read_word(12'h1c0, d, r);
		chk(d, UNMAPPED_READ);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		$display("test bus errors done");
		sweep("writes ignored");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < BANK_WORDS; i++) begin
			rows[i].want = WORD_RESET;
		end
		sweep("second reset");
		tally_and_finish();
	end
endmodule

`default_nettype wire
